// ==== inc/mfr_cfg_pkg.sv ====
// package for the manufacturer configuration bank: command codes, fields, resets
// assumes a byte-oriented command port fed by an upstream bus protocol engine
package mfr_cfg_pkg;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_VIOL_CROWBAR = 8'hD8;
  localparam logic [7:0] CMD_EXT_GAIN     = 8'hD9;
  localparam logic [7:0] CMD_EXT_BIAS     = 8'hDA;
  localparam logic [7:0] CMD_ALERT_MASK   = 8'hDB;
  localparam logic [7:0] CMD_TEMP_CORR    = 8'hDC;
  localparam logic [7:0] CMD_GAP_TIMES    = 8'hDD;
  localparam logic [7:0] CMD_GAP_MODE     = 8'hDE;
  localparam logic [7:0] CMD_LOOP_TUNE    = 8'hDF;

  // ==========================================================================
  // field positions
  localparam int VIOL_CNT_MSB   = 3;
  localparam int CROWBAR_BIT    = 7;
  localparam int TC_MSB         = 6;
  localparam int TC_SRC_BIT     = 7;
  localparam int HL_MODE_BIT    = 15;
  localparam int LH_MODE_BIT    = 7;
  localparam int LOOP_EN_BIT    = 24;
  localparam int ALERT_BYTES    = 7;
  localparam int ALERT_BITS     = 56;
  localparam int MAX_DATA_BYTES = 7;

  // ==========================================================================
  // reset values (the adaptive maximum reset is 60 ns per edge)
  localparam logic [7:0]  GAP_MAX_DEFAULT = 8'h3C;
  localparam logic [15:0] GAP_MAX_RESET   = {GAP_MAX_DEFAULT, GAP_MAX_DEFAULT};
  localparam logic [15:0] GAP_TIMES_RESET = 16'h0000;
  localparam logic [55:0] ALERT_MASK_RESET = 56'h00000000000000;
  localparam logic [7:0]  CNT_ZERO        = 8'h00;
  localparam logic [7:0]  BYTE_ONE        = 8'h01;

  // status bytes in mask order
  typedef struct packed {
    logic [7:0] mfr;
    logic [7:0] other;
    logic [7:0] cml;
    logic [7:0] temp;
    logic [7:0] input_s;
    logic [7:0] iout;
    logic [7:0] vout;
  } status_bytes_t;

  // command port beat
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       start;
    logic [7:0] cmd;
    logic [7:0] data;
  } cmd_beat_t;

  // dead-time control handed to the switch driver
  typedef struct packed {
    logic [7:0] hl_fixed;
    logic [7:0] lh_fixed;
    logic [7:0] hl_max;
    logic [7:0] lh_max;
    logic [6:0] hl_min;
    logic [6:0] lh_min;
    logic       hl_freeze;
    logic       lh_freeze;
  } gap_ctl_t;

endpackage

// ==== rtl/mfr_cfg_bank.sv ====
// register bank for manufacturer configuration commands plus the logic they steer
// assumes a protocol engine presents bytes of each command, low byte first
//
// Operation
// - fault response after count plus one violations
// - crowbar bit turns low switch on
// - seven-byte alert mask, status order
// - mask one blocks alert, zero allows
// - manufacturer mask byte bits 55 to 48
// - monitor warnings at 110 and 95 percent
// - sync loss flags period fault, bit 51
// - communication mask bits 39 38 37 33
// - temperature mask bits 31 down to 25
// - input, current, output mask bit mapping
// - sense resistance corrected by coefficient field
// - source bit picks internal or external sensor while sensor enable is set
// - two signed eight-bit dead-time fields
// - times before mode write set maximum
// - fixed times used when adaptive disabled
// - signed minimum dead times, 2 ns steps
// - mode bits select adaptive or freeze
// - loop tuning gain, residual, enable
// - external readback divides by scale plus offset
// - snapshot bits block output fault triggers
`timescale 1ns/1ps
module mfr_cfg_bank
  import mfr_cfg_pkg::*;
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // command port from protocol engine
  input  wire mfr_cfg_pkg::cmd_beat_t     beat,
  output logic [7:0]                      rd_data,
  output logic                            rd_valid,
  // fault sources
  input  wire mfr_cfg_pkg::status_bytes_t status,
  input  wire logic                       vout_ov_raw,
  input  wire logic                       vout_uv_raw,
  input  wire logic                       cycle_tick,
  input  wire logic                       sync_present,
  input  wire logic [15:0]                aux_voltage_monitor_level,
  input  wire logic [15:0]                aux_voltage_monitor_uv_limit,
  input  wire logic [15:0]                aux_voltage_monitor_ov_limit,
  input  wire logic [1:0]                 snap_mask,
  input  wire logic                       ext_sense_en,
  // steered outputs
  output logic                            alert_output,
  output logic                            vout_ov_fault,
  output logic                            vout_uv_fault,
  output logic                            low_switch_on,
  output logic                            period_fault,
  output logic                            aux_voltage_monitor_uv_warn,
  output logic                            aux_voltage_monitor_ov_warn,
  output logic                            snapshot_req,
  output logic                            use_ext_sensor,
  output logic [6:0]                      temp_coefficient,
  output logic [15:0]                     ext_scale,
  output logic [15:0]                     ext_offset,
  output mfr_cfg_pkg::gap_ctl_t           gap,
  output logic [15:0]                     loop_gain,
  output logic [7:0]                      loop_residual,
  output logic                            loop_enable
);

  // ==========================================================================
  // registers
  logic [7:0]  viol_cfg_q;
  logic [15:0] gain_q;
  logic [15:0] bias_q;
  logic [55:0] mask_q;
  logic [7:0]  corr_q;
  logic [15:0] times_q;
  logic [15:0] mode_q;
  logic [31:0] tune_q;
  logic [15:0] gap_max_q;
  logic        last_was_times_q;
  logic [2:0]  idx_q;
  logic [7:0]  cmd_q;
  logic [55:0] shadow_q;

  // ==========================================================================
  // command byte decode: bytes collect into a shadow, commit on last byte
  wire  [2:0]  idx_now   = beat.start ? 3'h0 : idx_q;
  wire  [7:0]  cmd_now   = beat.start ? beat.cmd : cmd_q;
  wire  [2:0]  cmd_bytes = (cmd_now == CMD_VIOL_CROWBAR) ? 3'h1 :
                           (cmd_now == CMD_TEMP_CORR)    ? 3'h1 :
                           (cmd_now == CMD_ALERT_MASK)   ? 3'h7 :
                           (cmd_now == CMD_LOOP_TUNE)    ? 3'h4 : 3'h2;
  wire         known     = (cmd_now >= CMD_VIOL_CROWBAR) && (cmd_now <= CMD_LOOP_TUNE);
  wire         last_byte = known && (idx_now == cmd_bytes - 3'h1);
  wire         commit    = beat.wr && last_byte;
  logic [55:0] shadow_d;
  always_comb begin
    shadow_d = shadow_q;
    shadow_d[{idx_now, 3'h0} +: 8] = beat.data;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      idx_q    <= 3'h0;
      cmd_q    <= 8'h00;
      shadow_q <= 56'h00000000000000;
    end else begin
      if (beat.start)
        cmd_q <= beat.cmd;
      if ((beat.wr || beat.rd) && idx_now != 3'h7)
        idx_q <= idx_now + 3'h1;
      else if (beat.start)
        idx_q <= 3'h0;
      if (beat.wr)
        shadow_q <= shadow_d;
    end
  end

  // ==========================================================================
  // register writes: one named strobe per command, decoded outside the flops
  wire         wr_viol   = commit && (cmd_now == CMD_VIOL_CROWBAR);
  wire         wr_gain   = commit && (cmd_now == CMD_EXT_GAIN);
  wire         wr_bias   = commit && (cmd_now == CMD_EXT_BIAS);
  wire         wr_mask   = commit && (cmd_now == CMD_ALERT_MASK);
  wire         wr_corr   = commit && (cmd_now == CMD_TEMP_CORR);
  wire         wr_times  = commit && (cmd_now == CMD_GAP_TIMES);
  wire         wr_mode   = commit && (cmd_now == CMD_GAP_MODE);
  wire         wr_tune   = commit && (cmd_now == CMD_LOOP_TUNE);
  // times then mode sets maximum
  // reads and partial writes leave the chain intact, only commits break it
  wire         max_load  = wr_mode && last_was_times_q;

  // byte-wide commands
  always_ff @(posedge clk) begin
    if (!nrst) begin
      viol_cfg_q <= 8'h00;
      corr_q     <= 8'h00;
    end else begin
      if (wr_viol)
        viol_cfg_q <= shadow_d[7:0];
      if (wr_corr)
        corr_q <= shadow_d[7:0];
    end
  end

  // word and block commands
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gain_q <= 16'h0000;
      bias_q <= 16'h0000;
      tune_q <= 32'h00000000;
    end else begin
      if (wr_gain)
        gain_q <= shadow_d[15:0];
      if (wr_bias)
        bias_q <= shadow_d[15:0];
      if (wr_tune)
        tune_q <= shadow_d[31:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      mask_q <= ALERT_MASK_RESET;
    else if (wr_mask)
      mask_q <= shadow_d;
  end

  // dead-time commands and the adaptive maximum
  always_ff @(posedge clk) begin
    if (!nrst) begin
      times_q          <= GAP_TIMES_RESET;
      mode_q           <= 16'h0000;
      gap_max_q        <= GAP_MAX_RESET;
      last_was_times_q <= 1'b0;
    end else begin
      if (commit)
        last_was_times_q <= wr_times;
      if (wr_times)
        times_q <= shadow_d[15:0];
      if (wr_mode)
        mode_q <= shadow_d[15:0];
      if (max_load)
        gap_max_q <= times_q;
    end
  end

  // ==========================================================================
  // readback
  logic [55:0] rd_word;
  always_comb begin
    case (cmd_now)
      CMD_VIOL_CROWBAR: rd_word = {48'h0, viol_cfg_q};
      CMD_EXT_GAIN:     rd_word = {40'h0, gain_q};
      CMD_EXT_BIAS:     rd_word = {40'h0, bias_q};
      CMD_ALERT_MASK:   rd_word = mask_q;
      CMD_TEMP_CORR:    rd_word = {48'h0, corr_q};
      CMD_GAP_TIMES:    rd_word = {40'h0, times_q};
      CMD_GAP_MODE:     rd_word = {40'h0, mode_q};
      CMD_LOOP_TUNE:    rd_word = {24'h0, tune_q};
      default:          rd_word = 56'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= beat.rd;
      rd_data  <= beat.rd ? rd_word[{idx_now, 3'h0} +: 8] : 8'h00;
    end
  end

  // ==========================================================================
  // output voltage violation counting; each tick samples the comparators
  logic [4:0] ov_cnt_q;
  logic [4:0] uv_cnt_q;
  wire  [4:0] need   = {1'b0, viol_cfg_q[VIOL_CNT_MSB:0]} + 5'h1;
  wire  [4:0] ov_inc = ov_cnt_q + 5'h1;
  wire  [4:0] uv_inc = uv_cnt_q + 5'h1;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ov_cnt_q      <= 5'h00;
      uv_cnt_q      <= 5'h00;
      vout_ov_fault <= 1'b0;
      vout_uv_fault <= 1'b0;
    end else if (cycle_tick) begin
      ov_cnt_q      <= vout_ov_raw ? ((ov_inc >= need) ? need : ov_inc) : 5'h00;
      uv_cnt_q      <= vout_uv_raw ? ((uv_inc >= need) ? need : uv_inc) : 5'h00;
      vout_ov_fault <= vout_ov_raw && (ov_inc >= need);
      vout_uv_fault <= vout_uv_raw && (uv_inc >= need);
    end
  end

  // ==========================================================================
  // sync input passes three flops; a change counts when stages two and three agree
  logic [2:0] sync_sr_q;
  logic       sync_ok_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_sr_q <= 3'h7;
      sync_ok_q <= 1'b1;
    end else begin
      sync_sr_q <= {sync_sr_q[1:0], sync_present};
      if (sync_sr_q[2] == sync_sr_q[1])
        sync_ok_q <= sync_sr_q[2];
    end
  end

  // ==========================================================================
  // monitor warnings: integer division rounds both margins down
  // warn at 110 and 95 percent
  wire [19:0] uv_warn_lim = 20'(aux_voltage_monitor_uv_limit) + 20'(aux_voltage_monitor_uv_limit / 16'h000A);
  wire [19:0] ov_warn_lim = 20'(aux_voltage_monitor_ov_limit) - 20'(aux_voltage_monitor_ov_limit / 16'h0014);
  wire        uv_warn_now = 20'(aux_voltage_monitor_level) < uv_warn_lim;
  wire        ov_warn_now = 20'(aux_voltage_monitor_level) > ov_warn_lim;

  // ==========================================================================
  // alert output: status readable elsewhere, masking gates only the alert
  status_bytes_t live;
  always_comb begin
    live          = status;
    live.vout[7]  = status.vout[7] | vout_ov_fault;
    live.vout[4]  = status.vout[4] | vout_uv_fault;
    live.mfr[3]   = status.mfr[3] | period_fault;
    live.mfr[5]   = status.mfr[5] | aux_voltage_monitor_uv_warn;
    live.mfr[4]   = status.mfr[4] | aux_voltage_monitor_ov_warn;
  end
  wire [ALERT_BITS-1:0] live_flat = live;
  logic [ALERT_BITS-1:0] pass;
  genvar b;
  generate
    for (b = 0; b < ALERT_BITS; b = b + 1) begin : g_mask
      assign pass[b] = live_flat[b] & ~mask_q[b];
    end
  endgenerate

  // ==========================================================================
  // steered outputs, all registered
  // crowbar on over-voltage fault
  wire         crowbar_d = vout_ov_fault && viol_cfg_q[CROWBAR_BIT];
  wire         snap_uv   = vout_uv_fault && !snap_mask[1];
  wire         snap_ov   = vout_ov_fault && !snap_mask[0];
  // source bit with sensor enable
  // the sensor enable belongs to another bank, so it arrives here as a level
  wire         ext_pick  = corr_q[TC_SRC_BIT] && ext_sense_en;

  // fault and alert flags
  always_ff @(posedge clk) begin
    if (!nrst) begin
      alert_output  <= 1'b0;
      low_switch_on <= 1'b0;
      period_fault  <= 1'b0;
      aux_voltage_monitor_uv_warn  <= 1'b0;
      aux_voltage_monitor_ov_warn  <= 1'b0;
      snapshot_req  <= 1'b0;
    end else begin
      alert_output  <= |pass;
      low_switch_on <= crowbar_d;
      period_fault  <= ~sync_ok_q;
      aux_voltage_monitor_uv_warn  <= uv_warn_now;
      aux_voltage_monitor_ov_warn  <= ov_warn_now;
      snapshot_req  <= snap_uv || snap_ov;
    end
  end

  // sensing configuration copies
  always_ff @(posedge clk) begin
    if (!nrst) begin
      use_ext_sensor   <= 1'b0;
      temp_coefficient <= 7'h00;
      ext_scale        <= 16'h0000;
      ext_offset       <= 16'h0000;
    end else begin
      use_ext_sensor   <= ext_pick;
      temp_coefficient <= corr_q[TC_MSB:0];
      ext_scale        <= gain_q;
      ext_offset       <= bias_q;
    end
  end

  // dead-time control; the maximum leaves reset at its default, never at zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gap.hl_fixed  <= 8'h00;
      gap.lh_fixed  <= 8'h00;
      gap.hl_max    <= GAP_MAX_DEFAULT;
      gap.lh_max    <= GAP_MAX_DEFAULT;
      gap.hl_min    <= 7'h00;
      gap.lh_min    <= 7'h00;
      gap.hl_freeze <= 1'b0;
      gap.lh_freeze <= 1'b0;
    end else begin
      gap.hl_fixed  <= times_q[15:8];
      gap.lh_fixed  <= times_q[7:0];
      gap.hl_max    <= gap_max_q[15:8];
      gap.lh_max    <= gap_max_q[7:0];
      gap.hl_min    <= mode_q[14:8];
      gap.lh_min    <= mode_q[6:0];
      gap.hl_freeze <= mode_q[HL_MODE_BIT];
      gap.lh_freeze <= mode_q[LH_MODE_BIT];
    end
  end

  // loop tuning copies
  always_ff @(posedge clk) begin
    if (!nrst) begin
      loop_gain     <= 16'h0000;
      loop_residual <= 8'h00;
      loop_enable   <= 1'b0;
    end else begin
      loop_gain     <= tune_q[15:0];
      loop_residual <= tune_q[23:16];
      loop_enable   <= tune_q[LOOP_EN_BIT];
    end
  end

endmodule

// ==== testbench/mfr_cfg_bank_sva.sv ====
// assertions on the configuration bank ports
// assumes it is bound onto the bank and sees its port names
`timescale 1ns/1ps
module mfr_cfg_bank_sva
  import mfr_cfg_pkg::*;
(
  // clock and reset
  input wire logic                       clk,
  input wire logic                       nrst,
  // command port
  input wire mfr_cfg_pkg::cmd_beat_t     beat,
  input wire logic                       rd_valid,
  // sources
  input wire mfr_cfg_pkg::status_bytes_t status,
  input wire logic                       vout_ov_raw,
  input wire logic                       cycle_tick,
  input wire logic                       sync_present,
  input wire logic [15:0]                aux_voltage_monitor_level,
  input wire logic [15:0]                aux_voltage_monitor_ov_limit,
  input wire logic [1:0]                 snap_mask,
  // steered outputs
  input wire logic                       alert_output,
  input wire logic                       vout_ov_fault,
  input wire logic                       vout_uv_fault,
  input wire logic                       low_switch_on,
  input wire logic                       period_fault,
  input wire logic                       aux_voltage_monitor_uv_warn,
  input wire logic                       aux_voltage_monitor_ov_warn,
  input wire logic                       snapshot_req
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // three quiet cycles cover the status input, the fault flags and the warnings
  sequence s_quiet;
    (status == '0 && !vout_ov_fault && !vout_uv_fault && !period_fault &&
     !aux_voltage_monitor_uv_warn && !aux_voltage_monitor_ov_warn) [*3];
  endsequence
  sequence s_sync_lost;
    !sync_present [*6];
  endsequence
  a_read_answer: assert property (beat.rd |=> rd_valid)
    else $error("read answer missing");
  a_ov_onset_tick: assert property ($rose(vout_ov_fault) |-> $past(cycle_tick && vout_ov_raw))
    else $error("fault raised off a violating tick");
  a_ov_clear_tick: assert property ($fell(vout_ov_fault) |-> $past(cycle_tick && !vout_ov_raw))
    else $error("fault cleared off a clean tick");
  a_crowbar_needs_fault: assert property (low_switch_on |-> vout_ov_fault || $past(vout_ov_fault))
    else $error("low switch on without fault");
  a_period_on_loss: assert property (s_sync_lost |-> period_fault)
    else $error("period fault missing on sync loss");
  a_ov_warn_level: assert property
    ((aux_voltage_monitor_level > aux_voltage_monitor_ov_limit - aux_voltage_monitor_ov_limit / 16'h0014) [*2] |-> aux_voltage_monitor_ov_warn)
    else $error("monitor warning missing");
  a_snap_blocked: assert property ((snap_mask == 2'h3) [*3] |-> !snapshot_req)
    else $error("snapshot not blocked");
  a_alert_quiet: assert property (s_quiet |-> !alert_output)
    else $error("alert without cause");
endmodule

bind mfr_cfg_bank mfr_cfg_bank_sva u_sva (
  .clk(clk), .nrst(nrst), .beat(beat), .rd_valid(rd_valid), .status(status),
  .vout_ov_raw(vout_ov_raw), .cycle_tick(cycle_tick), .sync_present(sync_present),
  .aux_voltage_monitor_level(aux_voltage_monitor_level), .aux_voltage_monitor_ov_limit(aux_voltage_monitor_ov_limit), .snap_mask(snap_mask),
  .alert_output(alert_output), .vout_ov_fault(vout_ov_fault), .low_switch_on(low_switch_on),
  .period_fault(period_fault), .aux_voltage_monitor_uv_warn(aux_voltage_monitor_uv_warn), .aux_voltage_monitor_ov_warn(aux_voltage_monitor_ov_warn),
  .snapshot_req(snapshot_req), .vout_uv_fault(vout_uv_fault)
);

// ==== testbench/cfg_host.sv ====
// host model issuing command beats to the configuration bank
// assumes one beat per clock and reads answered one cycle after the beat
`timescale 1ns/1ps
module cfg_host
  import mfr_cfg_pkg::*;
(
  // clock
  input  wire logic              clk,
  // command port
  output mfr_cfg_pkg::cmd_beat_t beat,
  input  wire logic [7:0]        rd_data,
  input  wire logic              rd_valid
);
  initial beat = '0;
  // ==========================================================================
  // transfer
  // n bytes of one command, low byte first
  task automatic xfer(input logic [7:0] cmd, input int n, input logic wr,
                      input logic [55:0] wd, output logic [55:0] rdat);
    rdat = '0;
    @(posedge clk);
    #1;
    for (int i = 0; i < n; i++) begin
      beat = '{wr, !wr, (i == 0), cmd, wd[8*i+:8]};
      @(posedge clk);
      #1;
      rdat[8*i+:8] = rd_valid ? rd_data : 8'hXX;
    end
    // released data line flips so a stale byte is never mistaken for data
    beat = '{1'b0, 1'b0, 1'b0, cmd, ~beat.data};
  endtask
endmodule

// ==== testbench/mfr_cfg_bank_tb_top.sv ====
// self-checking bench for the configuration bank
// assumes the host model drives the command port and the bench the sources
`timescale 1ns/1ps
module mfr_cfg_bank_tb_top;
  import mfr_cfg_pkg::*;
  logic          clk = 1'b0;
  logic          nrst = 1'b0;
  cmd_beat_t     beat;
  logic [7:0]    rd_data;
  logic          rd_valid;
  status_bytes_t status = '0;
  logic          vout_ov_raw = 1'b0, vout_uv_raw = 1'b0, cycle_tick = 1'b0;
  logic          sync_present = 1'b1, ext_sense_en = 1'b1;
  logic [15:0]   aux_voltage_monitor_level = 16'h0000, aux_voltage_monitor_uv_limit = 16'h0000, aux_voltage_monitor_ov_limit = 16'h0000;
  logic [1:0]    snap_mask = 2'h0;
  logic          alert_output, vout_ov_fault, vout_uv_fault, low_switch_on, period_fault;
  logic          aux_voltage_monitor_uv_warn, aux_voltage_monitor_ov_warn, snapshot_req, use_ext_sensor, loop_enable;
  logic [6:0]    temp_coefficient;
  logic [15:0]   ext_scale, ext_offset, loop_gain;
  logic [7:0]    loop_residual;
  gap_ctl_t      gap;
  int            err_total = 0;
  int            n_tests = 0;
  int            last_k = -1;
  logic [55:0]   m [8] = '{default: '0};
  logic [15:0]   max_m = GAP_MAX_RESET;
  logic [55:0]   rd;

  always #50 clk = ~clk;

  mfr_cfg_bank u_dut (
    .clk(clk), .nrst(nrst), .beat(beat), .rd_data(rd_data), .rd_valid(rd_valid),
    .status(status), .vout_ov_raw(vout_ov_raw), .vout_uv_raw(vout_uv_raw),
    .cycle_tick(cycle_tick), .sync_present(sync_present), .aux_voltage_monitor_level(aux_voltage_monitor_level),
    .aux_voltage_monitor_uv_limit(aux_voltage_monitor_uv_limit), .aux_voltage_monitor_ov_limit(aux_voltage_monitor_ov_limit), .snap_mask(snap_mask),
    .ext_sense_en(ext_sense_en), .alert_output(alert_output), .vout_ov_fault(vout_ov_fault),
    .vout_uv_fault(vout_uv_fault), .low_switch_on(low_switch_on), .period_fault(period_fault),
    .aux_voltage_monitor_uv_warn(aux_voltage_monitor_uv_warn), .aux_voltage_monitor_ov_warn(aux_voltage_monitor_ov_warn), .snapshot_req(snapshot_req),
    .use_ext_sensor(use_ext_sensor), .temp_coefficient(temp_coefficient),
    .ext_scale(ext_scale), .ext_offset(ext_offset), .gap(gap), .loop_gain(loop_gain),
    .loop_residual(loop_residual), .loop_enable(loop_enable)
  );
  cfg_host u_host (.clk(clk), .beat(beat), .rd_data(rd_data), .rd_valid(rd_valid));

  // ==========================================================================
  // model and helpers
  function automatic logic [55:0] r56();
    return 56'({$urandom(), $urandom()});
  endfunction
  function automatic int blen(input int k);
    return (k == 3) ? 7 : (k == 7) ? 4 : (k == 0 || k == 4) ? 1 : 2;
  endfunction
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input int k, input logic [55:0] v);
    v = v & ((56'h1 << (8 * blen(k))) - 56'h1);
    u_host.xfer(8'(CMD_VIOL_CROWBAR + k), blen(k), 1'b1, v, rd);
    if (k == 6 && last_k == 5) max_m = m[5][15:0];
    m[k] = v;
    last_k = k;
  endtask
  task automatic rall;
    for (int k = 0; k < 8; k++) begin
      u_host.xfer(8'(CMD_VIOL_CROWBAR + k), blen(k), 1'b0, '0, rd);
      chk(rd, m[k]);
    end
  endtask
  task automatic outs;
    chk({gap.hl_fixed, gap.lh_fixed}, m[5][15:0]);
    chk({gap.hl_max, gap.lh_max}, max_m);
    chk({gap.hl_freeze, gap.hl_min, gap.lh_freeze, gap.lh_min}, m[6][15:0]);
    chk({use_ext_sensor, temp_coefficient}, {m[4][7] & ext_sense_en, m[4][6:0]});
    chk({ext_offset, ext_scale}, {m[2][15:0], m[1][15:0]});
    chk({loop_enable, loop_residual, loop_gain}, m[7][24:0]);
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
    cycle_tick = 1'b1;
    @(posedge clk);
    #1;
    cycle_tick = 1'b0;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial begin
    #(100 * 20000);
    err_total++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h9835));
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    rall();
    outs();
    repeat (2) for (int k = 0; k < 8; k++) put(k, r56());
    rall();
    outs();
    // partial word never commits, refused code, mode after a non-time write
    u_host.xfer(CMD_GAP_TIMES, 1, 1'b1, r56(), rd);
    u_host.xfer(8'hE0, 2, 1'b1, r56(), rd);
    put(4, r56());
    put(6, r56());
    rall();
    outs();
    for (int c = 0; c < 4; c++) begin
      int n;
      n = $urandom_range(3);
      put(0, 56'({c[0], 3'h0, 4'(n)}));
      snap_mask = 2'(c);
      if (c[1]) vout_uv_raw = 1'b1;
      else vout_ov_raw = 1'b1;
      for (int t = 0; t <= n; t++) begin
        tick();
        chk(c[1] ? vout_uv_fault : vout_ov_fault, t == n);
      end
      @(posedge clk);
      #1;
      chk(low_switch_on, c == 1);
      chk(snapshot_req, c[1] ? !snap_mask[1] : !snap_mask[0]);
      vout_ov_raw = 1'b0;
      vout_uv_raw = 1'b0;
      tick();
      chk({vout_uv_fault, vout_ov_fault}, 2'h0);
    end
    for (int i = 0; i < 24; i++) begin
      put(3, r56());
      status = r56() & r56() & r56();
      repeat (3) @(posedge clk);
      #1;
      chk(alert_output, |(status & ~m[3]));
    end
    put(3, 56'h0);
    status = '0;
    sync_present = 1'b0;
    aux_voltage_monitor_level = 16'h03E8;
    aux_voltage_monitor_uv_limit = 16'h03E8;
    aux_voltage_monitor_ov_limit = 16'h03E8;
    repeat (8) @(posedge clk);
    #1;
    chk({alert_output, period_fault, aux_voltage_monitor_uv_warn, aux_voltage_monitor_ov_warn}, 4'hF);
    put(3, 56'h38000000000000);
    repeat (3) @(posedge clk);
    #1;
    chk(alert_output, 1'b0);
    aux_voltage_monitor_level = 16'h03B6;
    repeat (3) @(posedge clk);
    #1;
    chk({aux_voltage_monitor_uv_warn, aux_voltage_monitor_ov_warn}, 2'h2);
    aux_voltage_monitor_level = 16'h044C;
    ext_sense_en = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({aux_voltage_monitor_uv_warn, aux_voltage_monitor_ov_warn}, 2'h1);
    outs();
    print_verdict();
  end
endmodule
